/* File: common/wdrs_pkg.sv */
// Package: constants and carrier types for the watchdog restart and standby block
package wdrs_pkg;

	// ---------------------------------------------------------------
	// Key and read-back values
	// ---------------------------------------------------------------
	localparam logic [7:0] WDRS_RESTART_KEY = 8'hAC;
	localparam logic [7:0] WDRS_READ_CONST = 8'h9A;

	// ---------------------------------------------------------------
	// Mode register fields and reset values
	// ---------------------------------------------------------------
	localparam int WDRS_MODE_STOP_BIT = 4;
	localparam int WDRS_MODE_SEL_LSB = 0;
	localparam int WDRS_MODE_SEL_W = 3;
	localparam logic [7:0] WDRS_MODE_RST = 8'h67;
	localparam logic [2:0] WDRS_SEL_NONSTOP = 3'h7;

	// ---------------------------------------------------------------
	// Counter and divider
	// ---------------------------------------------------------------
	localparam int WDRS_CNT_W = 16;
	localparam logic [15:0] WDRS_LIM_MIN = 16'h01FF;
	localparam int WDRS_DIV_W = 8;
	localparam logic [7:0] WDRS_DIV_CYCLES = 8'h20;

	// ---------------------------------------------------------------
	// Processor access to the two watchdog registers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic wr_key;
		logic wr_mode;
		logic bit_op;
		logic [7:0] data;
	} wdrs_acc_s;

endpackage

/* File: core/wdrs_counter.sv */
// Module: watchdog count register with clear, hold and overflow pulse
`timescale 1ns/1ps
`default_nettype none
module wdrs_counter import wdrs_pkg::*; #(
	parameter int W = WDRS_CNT_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic clear,
	input wire logic [W-1:0] limit,
	output logic [W-1:0] cnt,
	output logic ovf
);

	// Holding when tick is low keeps the count across standby
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
		end else if (clear) begin
			cnt <= '0;
		end else if (tick) begin
			if (cnt >= limit) begin
				cnt <= '0;
			end else begin
				cnt <= cnt + W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ovf <= 1'b0;
		end else begin
			ovf <= tick && !clear && (cnt >= limit);
		end
	end

endmodule
`default_nettype wire

/* File: core/wdrs_top.sv */
// Module: watchdog restart-key checking, mode lock and standby counting
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Wrong restart key forces internal reset.
// - Stoppable mode: reset deferred while source clock halted.
// - Single-bit access to restart register resets.
// - Restart register reads fixed non-key constant.
// - Non-stoppable mode: counter runs even in STOP.
// - Non-stoppable overflow in STOP resets device.
// - Stoppable mode: counting pauses in HALT/STOP.
// - Resume with clock select chosen before standby.
// - Count kept through standby, not cleared.
// - Mode register writable once; second write resets.
// - Clearing stop bit neither restarts nor resets.
module wdrs_top import wdrs_pkg::*; #(
	parameter logic [WDRS_DIV_W-1:0] DIV_CYCLES = WDRS_DIV_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic opt_nonstop,
	input wire logic src_clk_run,
	input wire logic cpu_halt,
	input wire logic cpu_stop,
	input wire wdrs_acc_s acc,
	output logic [7:0] key_rd_data,
	output logic [7:0] mode_rd_data,
	output logic [WDRS_CNT_W-1:0] count,
	output logic running,
	output logic reset_pending,
	output logic wdt_reset
);

	// ---------------------------------------------------------------
	// Option strap, captured once after reset release
	// ---------------------------------------------------------------
	logic strap_done_r;
	logic nonstop_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_done_r <= 1'b0;
			nonstop_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			nonstop_r <= opt_nonstop;
		end
	end

	// ---------------------------------------------------------------
	// Mode register and stop latch
	// ---------------------------------------------------------------
	logic [7:0] mode_r;
	logic mode_written_r;
	logic stopped_r;
	logic mode_ok;

	assign mode_ok = acc.wr_mode && !acc.bit_op && !mode_written_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= WDRS_MODE_RST;
			mode_written_r <= 1'b0;
		end else if (mode_ok) begin
			mode_r <= acc.data;
			mode_written_r <= 1'b1;
		end
	end

	// Sticky: a later clear of the bit cannot come through since writes lock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stopped_r <= 1'b0;
		end else if (mode_ok && !nonstop_r && acc.data[WDRS_MODE_STOP_BIT]) begin
			stopped_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Source clock state and count enable
	// ---------------------------------------------------------------
	logic run_now;
	logic cnt_en;
	logic [WDRS_MODE_SEL_W-1:0] sel;
	logic [WDRS_CNT_W-1:0] limit;

	// Non-stoppable mode ignores the halted-clock input entirely
	assign run_now = nonstop_r || (src_clk_run && !stopped_r);
	assign cnt_en = strap_done_r && run_now && (nonstop_r || !(cpu_halt || cpu_stop));
	// Select comes from the locked register (fixed WDRS_SEL_NONSTOP in non-stoppable mode), so standby cannot alter it
	assign sel = nonstop_r ? WDRS_SEL_NONSTOP
		: mode_r[WDRS_MODE_SEL_LSB +: WDRS_MODE_SEL_W];
	assign limit = (WDRS_LIM_MIN << sel) | ((16'h0001 << sel) - 16'h0001);

	// ---------------------------------------------------------------
	// Divider: one-cycle count enable
	// ---------------------------------------------------------------
	logic [WDRS_DIV_W-1:0] div_r;
	logic div_tick;
	logic key_ok;

	assign div_tick = (div_r == DIV_CYCLES - 8'h01);

	// Divider holds with the count, so the interval fraction survives standby
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_r <= '0;
		end else if (key_ok) begin
			div_r <= '0;
		end else if (cnt_en) begin
			div_r <= div_tick ? '0 : div_r + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// Restart register and fault detection
	// ---------------------------------------------------------------
	logic key_bad;
	logic key_bit;
	logic mode_again;
	logic ovf;
	logic fault;

	assign key_ok = acc.wr_key && !acc.bit_op && (acc.data == WDRS_RESTART_KEY);
	assign key_bad = acc.wr_key && !acc.bit_op && (acc.data != WDRS_RESTART_KEY);
	assign key_bit = acc.wr_key && acc.bit_op;
	assign mode_again = acc.wr_mode && mode_written_r;
	assign fault = key_bad || key_bit || mode_again || ovf;

	wdrs_counter #(
		.W(WDRS_CNT_W)
	) u_cnt (
		.clk(clk),
		.rstn(rstn),
		.tick(div_tick && cnt_en),
		.clear(key_ok),
		.limit(limit),
		.cnt(count),
		.ovf(ovf)
	);

	// ---------------------------------------------------------------
	// Internal reset request, deferred in stoppable mode while the source clock is halted
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reset_pending <= 1'b0;
		end else if (fault && !run_now) begin
			reset_pending <= 1'b1;
		end else if (run_now) begin
			reset_pending <= 1'b0;
		end
	end

	// Held until the system reset clears the block
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdt_reset <= 1'b0;
		end else if ((fault || reset_pending) && run_now) begin
			wdt_reset <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Read-back and status outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			key_rd_data <= WDRS_READ_CONST;
			mode_rd_data <= WDRS_MODE_RST;
			running <= 1'b0;
		end else begin
			key_rd_data <= WDRS_READ_CONST;
			mode_rd_data <= mode_r;
			running <= cnt_en;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	chk_bad_key_reset: assert property (key_bad && run_now |=> wdt_reset)
		else $error("wrong key did not reset");
	chk_defer_hold: assert property (
		fault && !run_now && !wdt_reset |=> !wdt_reset && reset_pending)
		else $error("reset not deferred while clock halted");
	chk_defer_fire: assert property (reset_pending && run_now |=> wdt_reset)
		else $error("deferred reset not raised on clock resume");
	chk_bit_op_reset: assert property (key_bit && run_now |=> wdt_reset)
		else $error("single-bit access did not reset");
	chk_read_const: assert property (##1 key_rd_data == WDRS_READ_CONST)
		else $error("restart register read-back wrong");
	chk_nonstop_runs: assert property (strap_done_r && nonstop_r && cpu_stop |-> cnt_en)
		else $error("counter stopped in non-stoppable mode");
	chk_ovf_reset: assert property (ovf && run_now |=> wdt_reset)
		else $error("overflow did not reset");
	chk_standby_pause: assert property (
		!nonstop_r && (cpu_halt || cpu_stop) && !key_ok |=> $stable(count))
		else $error("count moved during standby");
	chk_count_resume: assert property (
		!nonstop_r && $fell(cpu_halt || cpu_stop) && !$past(key_ok) |->
		count == $past(count))
		else $error("count not held across standby");
	chk_mode_twice: assert property (mode_again && run_now |=> wdt_reset)
		else $error("second mode write did not reset");
	chk_stop_sticky: assert property (stopped_r |=> stopped_r && !running)
		else $error("stopped watchdog restarted");
	chk_key_clears: assert property (key_ok |=> count == '0)
		else $error("correct key did not clear counter");
	chk_sel_locked: assert property (mode_written_r |=> $stable(mode_r))
		else $error("mode register changed after lock");

	cov_key_restart: cover property (cnt_en ##1 key_ok ##1 count == '0);
	cov_deferred: cover property (reset_pending ##[1:20] wdt_reset);
	cov_ovf: cover property (ovf ##1 wdt_reset);
	cov_standby: cover property (!nonstop_r && cpu_stop && count != '0);

endmodule
`default_nettype wire

/* File: dv/wdrs_top_test.sv */
// Testbench: restart key, mode lock and standby counting of the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdrs_top_test import wdrs_pkg::*; ;
	// ---------------------------------------------------------------
	// Stimulus and observed signals
	// ---------------------------------------------------------------
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic opt_nonstop = 1'h0;
	logic src_clk_run = 1'h1;
	logic cpu_halt = 1'h0;
	logic cpu_stop = 1'h0;
	wdrs_acc_s acc = '0;
	logic [7:0] key_rd_data;
	logic [7:0] mode_rd_data;
	logic [WDRS_CNT_W-1:0] count;
	logic running;
	logic reset_pending;
	logic wdt_reset;
	logic fast_reset;
	logic [15:0] held;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	typedef struct packed {
		logic ns;
		logic src;
		logic mode;
		logic bit_op;
		logic [7:0] data;
		logic twice;
		logic exp_rst;
		logic exp_pend;
	} wdrs_row_s;
	// Strap, source clock, access, expected reset and pending flags
	wdrs_row_s rows [8] = '{
		'{1'h0, 1'h1, 1'h0, 1'h0, 8'hAC, 1'h0, 1'h0, 1'h0},
		'{1'h0, 1'h1, 1'h0, 1'h0, 8'h55, 1'h0, 1'h1, 1'h0},
		'{1'h1, 1'h0, 1'h0, 1'h0, 8'h00, 1'h0, 1'h1, 1'h0},
		'{1'h0, 1'h1, 1'h0, 1'h1, 8'hAC, 1'h0, 1'h1, 1'h0},
		'{1'h0, 1'h0, 1'h0, 1'h0, 8'h55, 1'h0, 1'h0, 1'h1},
		'{1'h0, 1'h0, 1'h0, 1'h1, 8'hAC, 1'h0, 1'h0, 1'h1},
		'{1'h0, 1'h1, 1'h1, 1'h0, 8'h60, 1'h1, 1'h1, 1'h0},
		'{1'h0, 1'h1, 1'h1, 1'h0, 8'h60, 1'h0, 1'h0, 1'h0}
	};

	// Two-cycle divider keeps the short-interval tests quick
	wdrs_top #(.DIV_CYCLES(8'h02)) wdrs_top_inst (.clk(clk), .rstn(rstn),
		.opt_nonstop(opt_nonstop), .src_clk_run(src_clk_run), .cpu_halt(cpu_halt),
		.cpu_stop(cpu_stop), .acc(acc), .key_rd_data(key_rd_data),
		.mode_rd_data(mode_rd_data), .count(count), .running(running),
		.reset_pending(reset_pending), .wdt_reset(wdt_reset));
	// Fastest divider, so the fixed full-width interval fits in the run
	wdrs_top #(.DIV_CYCLES(8'h01)) wdrs_top_inst2 (.clk(clk), .rstn(rstn),
		.opt_nonstop(opt_nonstop), .src_clk_run(src_clk_run), .cpu_halt(cpu_halt),
		.cpu_stop(cpu_stop), .acc(acc), .key_rd_data(), .mode_rd_data(), .count(),
		.running(), .reset_pending(), .wdt_reset(fast_reset));

	always #2.5 clk = ~clk;

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			errors = errors + 1;
			complete_run();
		end
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("Checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic do_reset(input logic ns, input logic src);
		@(negedge clk);
		rstn = 1'h0;
		opt_nonstop = ns;
		src_clk_run = src;
		cpu_halt = 1'h0;
		cpu_stop = 1'h0;
		wait_cyc(10);
		rstn = 1'h1;
		wait_cyc(2);
	endtask

	// One-cycle strobe; caller leaves a cycle before the next one
	task automatic access(input logic mode, input logic bit_op, input logic [7:0] data);
		acc = '{~mode, mode, bit_op, data};
		@(negedge clk);
		acc = '0;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		do_reset(1'h0, 1'h1);
		check_val(count, 16'h0);
		check_val({8'h00, mode_rd_data}, {8'h00, WDRS_MODE_RST});
		check_val({8'h00, key_rd_data}, {8'h00, WDRS_READ_CONST});
		check_val({14'h0, wdt_reset, reset_pending}, 16'h0);
		foreach (rows[i]) begin
			do_reset(rows[i].ns, rows[i].src);
			access(rows[i].mode, rows[i].bit_op, rows[i].data);
			if (rows[i].twice) begin
				wait_cyc(1);
				access(rows[i].mode, rows[i].bit_op, rows[i].data);
			end
			wait_cyc(3);
			check_val({14'h0, wdt_reset, reset_pending}, {14'h0, rows[i].exp_rst, rows[i].exp_pend});
		end
		// Deferred fault fires once the source clock returns
		do_reset(1'h0, 1'h0);
		access(1'h0, 1'h0, 8'h55);
		wait_cyc(20);
		check_val({14'h0, wdt_reset, reset_pending}, 16'h1);
		src_clk_run = 1'h1;
		wait_cyc(3);
		check_val({14'h0, wdt_reset, reset_pending}, 16'h2);
		// Stop bit set, then a second write tries to clear it (ignored, locked): no restart, no reset
		do_reset(1'h0, 1'h1);
		access(1'h1, 1'h0, 8'h70);
		wait_cyc(3);
		held = count;
		access(1'h1, 1'h0, 8'h60);
		wait_cyc(20);
		check_val(count, held);
		check_val({14'h0, wdt_reset, running}, 16'h0);
		// Stoppable mode: shortest interval, then standby holds the count
		do_reset(1'h0, 1'h1);
		access(1'h1, 1'h0, 8'h60);
		wait_cyc(40);
		check_val({15'h0, count != 16'h0}, 16'h1);
		access(1'h0, 1'h0, WDRS_RESTART_KEY);
		check_val(count, 16'h0);
		check_val({8'h00, key_rd_data}, {8'h00, WDRS_READ_CONST});
		for (int i = 0; i < 2; i++) begin
			wait_cyc(20);
			cpu_halt = (i == 0);
			cpu_stop = (i == 1);
			wait_cyc(3);
			held = count;
			wait_cyc(20);
			check_val(count, held);
			check_val({15'h0, running}, 16'h0);
			cpu_halt = 1'h0;
			cpu_stop = 1'h0;
			wait_cyc(10);
			check_val({15'h0, count > held}, 16'h1);
			check_val({8'h00, mode_rd_data}, 16'h60);
		end
		for (int i = 0; i < 1200 && wdt_reset !== 1'h1; i++) wait_cyc(1);
		check_val({15'h0, wdt_reset}, 16'h1);
		// Non-stoppable mode keeps counting in STOP and overflows
		do_reset(1'h1, 1'h0);
		cpu_stop = 1'h1;
		wait_cyc(5);
		held = count;
		wait_cyc(20);
		check_val({15'h0, count > held}, 16'h1);
		check_val({15'h0, running}, 16'h1);
		access(1'h0, 1'h0, WDRS_RESTART_KEY);
		check_val(count, 16'h0);
		for (int i = 0; i < 70000 && fast_reset !== 1'h1; i++) wait_cyc(1);
		check_val({15'h0, fast_reset}, 16'h1);
		complete_run();
	end
endmodule
`default_nettype wire
